// ==== rtl/cafl_pkg.sv ====
// Package for the core address, flag and context block.
// Assumes one clock domain and an APB register port with byte addresses.
package cafl_pkg;
    // Register byte offsets.
    localparam logic [11:0] OFS_PSW  = 12'h000;
    localparam logic [11:0] OFS_IDX  = 12'h004;
    localparam logic [11:0] OFS_LEN  = 12'h008;
    localparam logic [11:0] OFS_OFF  = 12'h00c;
    localparam logic [11:0] OFS_SOP  = 12'h010;
    localparam logic [11:0] OFS_SAMT = 12'h014;
    localparam logic [11:0] OFS_SRES = 12'h018;
    localparam logic [11:0] OFS_DVA  = 12'h01c;
    localparam logic [11:0] OFS_DVB  = 12'h020;
    localparam logic [11:0] OFS_FREE = 12'h024;
    localparam logic [11:0] OFS_CMD  = 12'h028;
    localparam logic [11:0] OFS_STAT = 12'h02c;
    localparam logic [11:0] OFS_MASK = 12'h030;
    localparam logic [11:0] OFS_LOOP = 12'h034;
    localparam logic [11:0] OFS_EA   = 12'h038;
    localparam logic [11:0] OFS_TRAP = 12'h03c;
    localparam logic [5:0]  CTX_WIN  = 6'h01;
    localparam logic [3:0]  MEM_WIN  = 4'h1;
    // Status word fields.
    localparam int PSW_AV  = 0;
    localparam int PSW_V   = 1;
    localparam int PSW_SV  = 2;
    localparam int CALL_DEPTH_COUNT_ENABLE = 7;
    localparam int CALL_DEPTH_COUNTER_FIELD = 8;
    // Command word fields.
    localparam int CMD_VAR = 4;
    localparam int CMD_CAN = 8;
    // Interrupt status bits.
    localparam int ST_FCU  = 0;
    localparam int ST_CDO  = 1;
    localparam int ST_CDU  = 2;
    localparam int ST_WRAP = 3;
    // Reset values and limits.
    localparam logic [7:0]  FREE_RST  = 8'h04;
    localparam logic [7:0]  FREE_FULL = 8'h04;
    localparam logic [6:0]  CDC_TRACE = 7'h7e;
    localparam logic [6:0]  CDC_MAX   = 7'h3f;
    localparam logic [31:0] SAT_POS   = 32'h7fffffff;
    localparam logic [31:0] SAT_NEG   = 32'h80000000;
    typedef enum logic [3:0] {OP_NONE, OP_CIRC, OP_SATURATING_ARITH_SHIFT, OP_CALL, OP_RET, OP_SAVE,
                              OP_LOOPU, OP_STORE_LOWER_CONTEXT_INSTR, OP_LOAD_LOWER_CONTEXT_INSTR, OP_DIVIDE_INIT_INSTR} cafl_op_t;
    typedef enum logic [1:0] {TRAP_NONE, TRAP_FCU, TRAP_CDO, TRAP_CDU} cafl_trap_t;
    typedef enum logic [2:0] {DV_W, DV_U, DV_B, DV_BU, DV_H, DV_HU} cafl_dv_t;
endpackage

// ==== rtl/cafl_core.sv ====
// Core execution logic for circular indexing, saturating shift flags,
// context traps, unconditional loops, lower context moves and divide init.
// Assumes an APB master on CLOCK; commands are issued by writing the command register.
// How it works
// - next index is index plus signed offset.
// - underflow below start adds buffer length.
// - add length only on genuine underflow.
// - saturating ops take flag before saturation.
// - advanced overflow is bit31 xor bit30.
// - empty free list or error raises underflow trap.
// - call at maximum depth raises overflow trap.
// - free underflow always wins over depth overflow.
// - trace mode call gives depth overflow trap, return gives depth underflow trap.
// - unconditional loop always taken, never mispredicted.
// - store lower context writes sixteen words at address.
// - second stored word is return address register.
// - load lower context skips first two words.
// - cancelled divide init leaves flags alone.
// - mispredict, dependency, async events all cancel.
// - divide init touches only three overflow flags.
`timescale 1ns/10ps
module cafl_core #(
    parameter int MEM_WORDS = 64
) (
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ
);
    if (MEM_WORDS != 64) begin : g_chk
        $error("MEM_WORDS must be 64 to fit the memory window");
    end

    logic [31:0]          psw_q;
    logic [15:0]          idx_q;
    logic [15:0]          len_q;
    logic [15:0]          off_q;
    logic [31:0]          sop_q;
    logic [5:0]           samt_q;
    logic [31:0]          sres_q;
    logic [31:0]          dva_q;
    logic [31:0]          dvb_q;
    logic [7:0]           free_q;
    logic [3:0]           stat_q;
    logic [3:0]           mask_q;
    logic [31:0]          loop_q;
    logic [5:0]           ea_q;
    cafl_pkg::cafl_trap_t trap_q;
    logic [31:0]          ctx_q [16];
    logic [31:0]          mem_q [MEM_WORDS];
    logic [31:0]          prdata_q;
    logic                 err_q;

    // Bus strobes; every access completes with no wait state.
    logic              wr;
    logic              cmd_go;
    cafl_pkg::cafl_op_t op;
    assign wr     = PSEL && PENABLE && PWRITE;
    assign cmd_go = wr && (PADDR == cafl_pkg::OFS_CMD);
    assign op     = cmd_go ? cafl_pkg::cafl_op_t'(PWDATA[3:0]) : cafl_pkg::OP_NONE;
    assign PREADY = 1'b1;
    assign PRDATA = prdata_q;
    assign PSLVERR = err_q;

    function automatic logic wr_at(input logic [11:0] a, input logic [11:0] ofs);
        wr_at = (a == ofs);
    endfunction

    // Circular index step, done in 18-bit signed arithmetic so that a large
    // index or length is never mistaken for a negative value.
    logic signed [17:0] c_sum;
    logic signed [17:0] c_len;
    logic [15:0]        c_next;
    logic               c_wrap;
    always_comb begin
        c_len  = signed'({2'b00, len_q});
        c_sum  = signed'({2'b00, idx_q}) + signed'({{2{off_q[15]}}, off_q});
        c_next = c_sum[15:0];
        c_wrap = 1'b0;
        if (off_q[15] && c_sum < 18'sd0) begin
            c_next = 16'(c_sum + c_len);
            c_wrap = 1'b1;
        end else if (!off_q[15] && c_sum >= c_len) begin
            c_next = 16'(c_sum - c_len);
            c_wrap = 1'b1;
        end
    end

    // Saturating shift: flags read from the wide unsaturated result.
    logic signed [63:0] s_full;
    logic [31:0]        s_sat;
    logic               s_av;
    logic               s_v;
    always_comb begin
        if (!samt_q[5]) begin
            s_full = signed'({{32{sop_q[31]}}, sop_q}) <<< samt_q[4:0];
        end else begin
            s_full = signed'({{32{sop_q[31]}}, sop_q}) >>> 6'(-samt_q);
        end
        s_av  = s_full[31] ^ s_full[30];
        s_v   = 1'b1;
        s_sat = s_full[31:0];
        if (s_full > 64'sh7fffffff) begin
            s_sat = cafl_pkg::SAT_POS;
        end else if (s_full < -64'sh80000000) begin
            s_sat = cafl_pkg::SAT_NEG;
        end else begin
            s_v = 1'b0;
        end
    end

    // Divide init overflow check; signed byte and halfword forms share the signed word test.
    cafl_pkg::cafl_dv_t dv_var;
    logic               dv_v;
    logic               dv_cancel;
    assign dv_var    = cafl_pkg::cafl_dv_t'(PWDATA[cafl_pkg::CMD_VAR +: 3]);
    assign dv_cancel = |PWDATA[cafl_pkg::CMD_CAN +: 3];
    always_comb begin
        dv_v = (dvb_q == 32'h0);
        if (dv_var == cafl_pkg::DV_W || dv_var == cafl_pkg::DV_B || dv_var == cafl_pkg::DV_H) begin
            dv_v = dv_v || (dva_q == cafl_pkg::SAT_NEG && dvb_q == 32'hffffffff);
        end
    end

    // Call, return and save outcome; an underflow trap masks any depth trap.
    logic [6:0]          cdc;
    logic                cde;
    logic                ctx_err;
    cafl_pkg::cafl_trap_t trap_d;
    logic [6:0]          cdc_d;
    logic [7:0]          free_d;
    assign cdc = psw_q[cafl_pkg::CALL_DEPTH_COUNTER_FIELD +: 7];
    assign cde = psw_q[cafl_pkg::CALL_DEPTH_COUNT_ENABLE];
    always_comb begin
        trap_d  = cafl_pkg::TRAP_NONE;
        cdc_d   = cdc;
        free_d  = free_q;
        ctx_err = (op == cafl_pkg::OP_RET) ? (free_q >= cafl_pkg::FREE_FULL) : (free_q == 8'h00);
        if (op == cafl_pkg::OP_CALL || op == cafl_pkg::OP_RET || op == cafl_pkg::OP_SAVE) begin
            if (ctx_err) begin
                trap_d = cafl_pkg::TRAP_FCU;
            end else if (op == cafl_pkg::OP_SAVE) begin
                free_d = free_q - 8'h01;
            end else if (op == cafl_pkg::OP_CALL) begin
                free_d = free_q - 8'h01;
                if (cde && (cdc == cafl_pkg::CDC_TRACE || cdc == cafl_pkg::CDC_MAX)) begin
                    trap_d = cafl_pkg::TRAP_CDO;
                end else if (cde) begin
                    cdc_d = cdc + 7'h01;
                end
            end else begin
                free_d = free_q + 8'h01;
                if (cde && (cdc == cafl_pkg::CDC_TRACE || cdc == 7'h00)) begin
                    trap_d = cafl_pkg::TRAP_CDU;
                end else if (cde) begin
                    cdc_d = cdc - 7'h01;
                end
            end
        end
    end

    // Status word: software writes, shift and divide init flags, depth count.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            psw_q <= 32'h0;
        end else if (wr && wr_at(PADDR, cafl_pkg::OFS_PSW)) begin
            psw_q <= PWDATA;
        end else if (op == cafl_pkg::OP_SATURATING_ARITH_SHIFT) begin
            psw_q[cafl_pkg::PSW_AV] <= s_av;
            psw_q[cafl_pkg::PSW_V]  <= s_v;
            psw_q[cafl_pkg::PSW_SV] <= psw_q[cafl_pkg::PSW_SV] | s_v;
        end else if (op == cafl_pkg::OP_DIVIDE_INIT_INSTR && !dv_cancel) begin
            psw_q[cafl_pkg::PSW_AV] <= 1'b0;
            psw_q[cafl_pkg::PSW_V]  <= dv_v;
            psw_q[cafl_pkg::PSW_SV] <= psw_q[cafl_pkg::PSW_SV] | dv_v;
        end else begin
            psw_q[cafl_pkg::CALL_DEPTH_COUNTER_FIELD +: 7] <= cdc_d;
        end
    end

    // Operand registers and the circular index.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            idx_q  <= 16'h0;
            len_q  <= 16'h0;
            off_q  <= 16'h0;
            sop_q  <= 32'h0;
            samt_q <= 6'h0;
            dva_q  <= 32'h0;
            dvb_q  <= 32'h0;
            ea_q   <= 6'h0;
            mask_q <= 4'h0;
        end else if (wr) begin
            if (PADDR == cafl_pkg::OFS_IDX) begin
                idx_q <= PWDATA[15:0];
            end else if (PADDR == cafl_pkg::OFS_LEN) begin
                len_q <= PWDATA[15:0];
            end else if (PADDR == cafl_pkg::OFS_OFF) begin
                off_q <= PWDATA[15:0];
            end else if (PADDR == cafl_pkg::OFS_SOP) begin
                sop_q <= PWDATA;
            end else if (PADDR == cafl_pkg::OFS_SAMT) begin
                samt_q <= PWDATA[5:0];
            end else if (PADDR == cafl_pkg::OFS_DVA) begin
                dva_q <= PWDATA;
            end else if (PADDR == cafl_pkg::OFS_DVB) begin
                dvb_q <= PWDATA;
            end else if (PADDR == cafl_pkg::OFS_EA) begin
                ea_q <= PWDATA[5:0];
            end else if (PADDR == cafl_pkg::OFS_MASK) begin
                mask_q <= PWDATA[3:0];
            end else if (op == cafl_pkg::OP_CIRC) begin
                idx_q <= c_next;
            end
        end
    end

    // Results, free list, trap record and the loop counter.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sres_q <= 32'h0;
            free_q <= cafl_pkg::FREE_RST;
            trap_q <= cafl_pkg::TRAP_NONE;
            loop_q <= 32'h0;
        end else begin
            if (op == cafl_pkg::OP_SATURATING_ARITH_SHIFT) begin
                sres_q <= s_sat;
            end
            if (wr && wr_at(PADDR, cafl_pkg::OFS_FREE)) begin
                free_q <= PWDATA[7:0];
            end else begin
                free_q <= free_d;
            end
            if (trap_d != cafl_pkg::TRAP_NONE) begin
                trap_q <= trap_d;
            end
            if (op == cafl_pkg::OP_LOOPU) begin
                loop_q <= loop_q + 32'h1;
            end
        end
    end

    // Sticky interrupt status; a new event wins over a write-one clear.
    logic [3:0] st_set;
    always_comb begin
        st_set = 4'h0;
        st_set[cafl_pkg::ST_FCU]  = (trap_d == cafl_pkg::TRAP_FCU);
        st_set[cafl_pkg::ST_CDO]  = (trap_d == cafl_pkg::TRAP_CDO);
        st_set[cafl_pkg::ST_CDU]  = (trap_d == cafl_pkg::TRAP_CDU);
        st_set[cafl_pkg::ST_WRAP] = (op == cafl_pkg::OP_CIRC) && c_wrap;
    end
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            stat_q <= 4'h0;
        end else if (wr && wr_at(PADDR, cafl_pkg::OFS_STAT)) begin
            stat_q <= (stat_q & ~PWDATA[3:0]) | st_set;
        end else begin
            stat_q <= stat_q | st_set;
        end
    end
    assign IRQ = |(stat_q & mask_q);

    // Lower context registers; load skips the link and return address words.
    for (genvar i = 0; i < 16; i++) begin : g_ctx
        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                ctx_q[i] <= 32'h0;
            end else if (wr && PADDR[11:6] == cafl_pkg::CTX_WIN && PADDR[5:2] == 4'(i)) begin
                ctx_q[i] <= PWDATA;
            end else if (op == cafl_pkg::OP_LOAD_LOWER_CONTEXT_INSTR && i >= 2) begin
                ctx_q[i] <= mem_q[6'(ea_q + 6'(i))];
            end
        end
    end

    // Context memory; the store copies all sixteen words in one cycle.
    // Word 1 is taken from the return address slot, not the status word.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            for (int k = 0; k < MEM_WORDS; k++) begin
                mem_q[k] <= 32'h0;
            end
        end else if (wr && PADDR[11:8] == cafl_pkg::MEM_WIN) begin
            mem_q[PADDR[7:2]] <= PWDATA;
        end else if (op == cafl_pkg::OP_STORE_LOWER_CONTEXT_INSTR) begin
            for (int k = 0; k < 16; k++) begin
                mem_q[6'(ea_q + 6'(k))] <= ctx_q[k];
            end
        end
    end

    // Read data is fetched in the setup cycle so it leaves a flip-flop.
    logic [31:0] rd;
    logic        bad;
    always_comb begin
        rd  = 32'h0;
        bad = 1'b0;
        if (PADDR == cafl_pkg::OFS_PSW) begin
            rd = psw_q;
        end else if (PADDR == cafl_pkg::OFS_IDX) begin
            rd = {16'h0, idx_q};
        end else if (PADDR == cafl_pkg::OFS_LEN) begin
            rd = {16'h0, len_q};
        end else if (PADDR == cafl_pkg::OFS_OFF) begin
            rd = {16'h0, off_q};
        end else if (PADDR == cafl_pkg::OFS_SOP) begin
            rd = sop_q;
        end else if (PADDR == cafl_pkg::OFS_SAMT) begin
            rd = {26'h0, samt_q};
        end else if (PADDR == cafl_pkg::OFS_SRES) begin
            rd = sres_q;
        end else if (PADDR == cafl_pkg::OFS_DVA) begin
            rd = dva_q;
        end else if (PADDR == cafl_pkg::OFS_DVB) begin
            rd = dvb_q;
        end else if (PADDR == cafl_pkg::OFS_FREE) begin
            rd = {24'h0, free_q};
        end else if (PADDR == cafl_pkg::OFS_CMD) begin
            rd = 32'h0;
        end else if (PADDR == cafl_pkg::OFS_STAT) begin
            rd = {28'h0, stat_q};
        end else if (PADDR == cafl_pkg::OFS_MASK) begin
            rd = {28'h0, mask_q};
        end else if (PADDR == cafl_pkg::OFS_LOOP) begin
            rd = loop_q;
        end else if (PADDR == cafl_pkg::OFS_EA) begin
            rd = {26'h0, ea_q};
        end else if (PADDR == cafl_pkg::OFS_TRAP) begin
            rd = {30'h0, trap_q};
        end else if (PADDR[11:6] == cafl_pkg::CTX_WIN && PADDR[1:0] == 2'b00) begin
            rd = ctx_q[PADDR[5:2]];
        end else if (PADDR[11:8] == cafl_pkg::MEM_WIN && PADDR[1:0] == 2'b00) begin
            rd = mem_q[PADDR[7:2]];
        end else begin
            bad = 1'b1;
        end
    end
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_q <= 32'h0;
            err_q    <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            prdata_q <= PWRITE ? 32'h0 : rd;
            err_q    <= bad;
        end
    end

    // Checks on the documented behaviour.
    a_circ_no_false_add: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (op == cafl_pkg::OP_CIRC && off_q[15] && {1'b0, idx_q} >= (17'h10000 - {1'b0, off_q}))
        |=> idx_q == $past(idx_q) + $past(off_q)) else $error("false wrap on underflow check");
    a_circ_in_range: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (op == cafl_pkg::OP_CIRC && idx_q < len_q && off_q[15] && {1'b0, len_q} >= (17'h10000 - {1'b0, off_q}))
        |=> idx_q < len_q) else $error("circular index left buffer");
    a_circ_pos_wrap: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (op == cafl_pkg::OP_CIRC && !off_q[15] && idx_q < len_q && off_q < len_q)
        |=> idx_q < len_q) else $error("positive overrun not wrapped");
    a_saturating_arith_shift_av_raw: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (op == cafl_pkg::OP_SATURATING_ARITH_SHIFT && sop_q == 32'h48000000 && samt_q == 6'h02)
        |=> !psw_q[cafl_pkg::PSW_AV] && sres_q == cafl_pkg::SAT_POS) else $error("flag taken after saturation");
    a_fcu_only: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (op == cafl_pkg::OP_CALL && free_q == 8'h00)
        |=> (trap_q == cafl_pkg::TRAP_FCU && !stat_q[cafl_pkg::ST_CDO]) [*2])
        else $error("depth trap beside underflow");
    a_trace_ret_fcu: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (op == cafl_pkg::OP_RET && free_q >= cafl_pkg::FREE_FULL && cde && cdc == cafl_pkg::CDC_TRACE
         && !stat_q[cafl_pkg::ST_CDU]) |=> !stat_q[cafl_pkg::ST_CDU] && stat_q[cafl_pkg::ST_FCU])
        else $error("trace return raised depth trap");
    a_cdo_at_max: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (op == cafl_pkg::OP_CALL && free_q != 8'h00 && cde && cdc == cafl_pkg::CDC_MAX)
        |=> trap_q == cafl_pkg::TRAP_CDO && $stable(psw_q[cafl_pkg::CALL_DEPTH_COUNTER_FIELD +: 7])) else $error("no depth overflow");
    a_loop_taken: assert property (@(posedge CLOCK) disable iff (!RST_N)
        op == cafl_pkg::OP_LOOPU |=> loop_q == $past(loop_q) + 32'h1) else $error("loop not taken");
    a_store_ra: assert property (@(posedge CLOCK) disable iff (!RST_N)
        op == cafl_pkg::OP_STORE_LOWER_CONTEXT_INSTR |=> mem_q[6'($past(ea_q) + 6'h01)] == $past(ctx_q[1])) else $error("word 1 wrong");
    a_load_skip: assert property (@(posedge CLOCK) disable iff (!RST_N)
        op == cafl_pkg::OP_LOAD_LOWER_CONTEXT_INSTR |=> $stable(ctx_q[0]) && $stable(ctx_q[1])
        && ctx_q[2] == mem_q[6'(ea_q + 6'h02)]) else $error("load lower context wrong");
    a_dv_cancel: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (op == cafl_pkg::OP_DIVIDE_INIT_INSTR && dv_cancel) |=> $stable(psw_q)) else $error("cancelled divide init moved flags");
    a_dv_fields: assert property (@(posedge CLOCK) disable iff (!RST_N)
        op == cafl_pkg::OP_DIVIDE_INIT_INSTR |=> psw_q[31:3] == $past(psw_q[31:3])) else $error("divide init touched other fields");
    c_circ_wrap: cover property (@(posedge CLOCK) disable iff (!RST_N) op == cafl_pkg::OP_CIRC && c_wrap);
    c_fcu_trap: cover property (@(posedge CLOCK) disable iff (!RST_N) trap_d == cafl_pkg::TRAP_FCU);
    c_store_load: cover property (@(posedge CLOCK) disable iff (!RST_N)
        op == cafl_pkg::OP_STORE_LOWER_CONTEXT_INSTR ##[1:20] op == cafl_pkg::OP_LOAD_LOWER_CONTEXT_INSTR);
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the core address, flag and context block.
// Assumes an APB slave that may add wait states, and FREE resetting to four.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
    typedef struct packed {logic [15:0] idx; logic [15:0] len; logic [15:0] off; logic [15:0] nxt; logic wrap;} cafl_circ_t;
    typedef struct packed {logic [7:0] free; logic [15:0] program_status_word; logic [3:0] op; logic [3:0] stat; logic [1:0] trap;} cafl_trow_t;
    logic        clock   = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] rdata;
    logic        rerr;
    int          error_cnt = 0;
    int          n_checks  = 0;
    // Circular steps: plain, underflow, large buffer without underflow, exact start, overrun.
    cafl_circ_t circ_rows[5] = '{
        '{16'h0010, 16'h0100, 16'h0004, 16'h0014, 1'b0},
        '{16'h0002, 16'h0100, 16'hfffc, 16'h00fe, 1'b1},
        '{16'hc000, 16'he000, 16'hfffc, 16'hbffc, 1'b0},
        '{16'h8000, 16'h9000, 16'h8000, 16'h0000, 1'b0},
        '{16'h00fc, 16'h0100, 16'h0004, 16'h0000, 1'b1}};
    // Trap cases: free count, status word, command, expected status bits and trap code.
    cafl_trow_t trap_rows[6] = '{
        '{8'h00, 16'h3f80, 4'h3, 4'h1, 2'h1},
        '{8'h04, 16'h3f80, 4'h3, 4'h2, 2'h2},
        '{8'h00, 16'h7e80, 4'h3, 4'h1, 2'h1},
        '{8'h04, 16'h7e80, 4'h4, 4'h1, 2'h1},
        '{8'h00, 16'h0000, 4'h5, 4'h1, 2'h1},
        '{8'h02, 16'h0080, 4'h4, 4'h4, 2'h3}};

    cafl_core #(.MEM_WORDS(64)) dut (
        .CLOCK   (clock),
        .RST_N   (rst_n),
        .PSEL    (psel),
        .PENABLE (penable),
        .PWRITE  (pwrite),
        .PADDR   (paddr),
        .PWDATA  (pwdata),
        .PRDATA  (prdata),
        .PREADY  (pready),
        .PSLVERR (pslverr),
        .IRQ     (irq)
    );

    // Free-running 10 MHz clock.
    always #50 clock = ~clock;

    // Prints the counts and the verdict, then stops the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One APB transfer; the request stands until PREADY is seen at a rising edge.
    // A spare edge follows the release so no signal is driven twice in one step.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k == 16) begin
            error_cnt++;
            conclude();
        end
        @(posedge clock);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
        apb(1'b0, a, 32'h00000000);
        `CHK(nm, ex, rdata)
    endtask

    // Main sequence: table rows first, then the hand-written cases.
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        foreach (circ_rows[i]) begin
            wr(cafl_pkg::OFS_IDX, {16'h0000, circ_rows[i].idx});
            wr(cafl_pkg::OFS_LEN, {16'h0000, circ_rows[i].len});
            wr(cafl_pkg::OFS_OFF, {16'h0000, circ_rows[i].off});
            wr(cafl_pkg::OFS_CMD, 32'h00000001);
            rd(cafl_pkg::OFS_IDX, {16'h0000, circ_rows[i].nxt}, "index");
            rd(cafl_pkg::OFS_STAT, {28'h0000000, circ_rows[i].wrap, 3'h0}, "wrap flag");
            wr(cafl_pkg::OFS_STAT, 32'h0000000f);
        end
        foreach (trap_rows[i]) begin
            wr(cafl_pkg::OFS_FREE, {24'h000000, trap_rows[i].free});
            wr(cafl_pkg::OFS_PSW, {16'h0000, trap_rows[i].program_status_word});
            wr(cafl_pkg::OFS_CMD, {28'h0000000, trap_rows[i].op});
            rd(cafl_pkg::OFS_STAT, {28'h0000000, trap_rows[i].stat}, "trap status");
            rd(cafl_pkg::OFS_TRAP, {30'h00000000, trap_rows[i].trap}, "trap code");
            wr(cafl_pkg::OFS_STAT, 32'h0000000f);
            rd(cafl_pkg::OFS_STAT, 32'h00000000, "no repeated trap");
        end
        $display("table tests done");
        // Interrupt: raised by a failed save, masked, then cleared.
        wr(cafl_pkg::OFS_FREE, 32'h00000000);
        wr(cafl_pkg::OFS_CMD, 32'h00000005);
        `CHK("irq masked", 1'b0, irq)
        wr(cafl_pkg::OFS_MASK, 32'h00000001);
        `CHK("irq raised", 1'b1, irq)
        wr(cafl_pkg::OFS_STAT, 32'h00000001);
        `CHK("irq cleared", 1'b0, irq)
        $display("interrupt test done");
        // Saturating shift: flag taken from the unsaturated result.
        wr(cafl_pkg::OFS_PSW, 32'h00000000);
        wr(cafl_pkg::OFS_SOP, 32'h48000000);
        wr(cafl_pkg::OFS_SAMT, 32'h00000002);
        wr(cafl_pkg::OFS_CMD, 32'h00000002);
        rd(cafl_pkg::OFS_SRES, 32'h7fffffff, "shift result");
        rd(cafl_pkg::OFS_PSW, 32'h00000006, "shift flags");
        wr(cafl_pkg::OFS_PSW, 32'h00000000);
        wr(cafl_pkg::OFS_SOP, 32'h20000000);
        wr(cafl_pkg::OFS_SAMT, 32'h00000001);
        wr(cafl_pkg::OFS_CMD, 32'h00000002);
        rd(cafl_pkg::OFS_PSW, 32'h00000001, "shift flags");
        $display("shift test done");
        // Divide init: every variant cancelled by one of the three causes in turn, then executed.
        wr(cafl_pkg::OFS_DVA, 32'h00000005);
        wr(cafl_pkg::OFS_DVB, 32'h00000000);
        for (int v = 0; v < 6; v++) begin
            wr(cafl_pkg::OFS_PSW, 32'h00000581);
            wr(cafl_pkg::OFS_CMD, 32'(32'h9 | (v << 4) | (32'h100 << (v % 3))));
            rd(cafl_pkg::OFS_PSW, 32'h00000581, "psw after cancel");
            wr(cafl_pkg::OFS_CMD, 32'(32'h9 | (v << 4)));
            rd(cafl_pkg::OFS_PSW, 32'h00000586, "psw after divide");
        end
        $display("divide test done");
        // Lower context stored at an offset window, then loaded back.
        for (int i = 0; i < 16; i++) wr(12'(12'h040 + 4 * i), 32'(32'ha000 + i));
        wr(cafl_pkg::OFS_EA, 32'h00000004);
        wr(cafl_pkg::OFS_CMD, 32'h00000007);
        for (int i = 0; i < 16; i++) rd(12'(12'h110 + 4 * i), 32'(32'ha000 + i), "stored word");
        for (int i = 0; i < 16; i++) wr(12'(12'h040 + 4 * i), 32'h00000000);
        wr(cafl_pkg::OFS_CMD, 32'h00000008);
        for (int i = 0; i < 16; i++) rd(12'(12'h040 + 4 * i), (i < 2) ? 32'h0 : 32'(32'ha000 + i), "loaded word");
        $display("context test done");
        // Unconditional loop is taken every time.
        repeat (3) wr(cafl_pkg::OFS_CMD, 32'h00000006);
        rd(cafl_pkg::OFS_LOOP, 32'h00000003, "loop taken");
        rd(12'h200, 32'h00000000, "unmapped read");
        `CHK("slave error", 1'b1, rerr)
        $display("loop and map test done");
        // Reset in mid-run brings back the reset values.
        wr(cafl_pkg::OFS_PSW, 32'h00000080);
        wr(cafl_pkg::OFS_FREE, 32'h00000000);
        wr(cafl_pkg::OFS_CMD, 32'h00000005);
        `CHK("irq before reset", 1'b1, irq)
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(cafl_pkg::OFS_FREE, 32'h00000004, "free after reset");
        rd(cafl_pkg::OFS_PSW, 32'h00000000, "psw after reset");
        rd(cafl_pkg::OFS_STAT, 32'h00000000, "status after reset");
        `CHK("irq after reset", 1'b0, irq)
        $display("reset test done");
        conclude();
    end
endmodule
